// file: rtl/sdg_top.sv
// Purpose: Four channel step and direction generator with EPP host link.
// Assumes: All pins synchronous to sys_clk.
// Notes:   Channel logic is one module used four times.
`timescale 1ns/1ps
`include "sdg_cfg.svh"

// ----------------------------------------
// One step channel
// ----------------------------------------
module sdg_chan (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire sdg_pkg::sdg_word_t freq,
    input  wire sdg_pkg::sdg_tick_t step_len,
    input  wire sdg_pkg::sdg_tick_t step_space,
    input  wire sdg_pkg::sdg_tick_t dir_time,
    output logic                   motion_pulse_out,
    output logic                   travel_sense_out,
    output sdg_pkg::sdg_word_t     position
);
    import sdg_pkg::*;
    logic [`SDG_ACC_W-1:0] acc, next_acc;
    logic [`SDG_ACC_W:0]   sum;
    logic                  pend, next_pend, next_step, next_dir;
    sdg_st_e               state, next_state;
    sdg_cyc_t              cnt, next_cnt, age, next_age, hlim, slim, dlim;
    sdg_word_t             next_pos;

    function automatic sdg_cyc_t lim(input sdg_tick_t tk);
        lim = sdg_cyc_t'((tk == 5'h00) ? 5'h01 : tk) * sdg_cyc_t'(`SDG_TICK_CYC);
    endfunction : lim

    assign hlim = lim(step_len);
    assign slim = lim(step_space);
    assign dlim = lim(dir_time);

    always_comb begin
        sum        = {1'b0, acc} + {8'h00, freq[14:0]};
        next_acc   = sum[`SDG_ACC_W-1:0];
        next_pend  = pend | sum[`SDG_ACC_W];
        next_state = state;
        next_cnt   = (cnt == 13'h1FFF) ? cnt : cnt + 13'h0001;
        next_age   = (age == 13'h1FFF) ? age : age + 13'h0001;
        next_dir   = travel_sense_out;
        next_pos   = position;
        case (state)
            SDG_IDLE: begin
                if (pend && freq[`SDG_DIR_BIT] != travel_sense_out) begin
                    if (age >= dlim) begin
                        next_dir   = freq[`SDG_DIR_BIT];
                        next_state = SDG_SETUP;
                        next_cnt   = 13'h0000;
                    end
                end else if (pend) begin
                    next_state = SDG_HIGH;
                    next_cnt   = 13'h0000;
                end
            end
            SDG_SETUP: begin
                if (cnt + 13'h0001 >= dlim) begin
                    next_state = SDG_HIGH;
                    next_cnt   = 13'h0000;
                end
            end
            SDG_HIGH: begin
                if (cnt + 13'h0001 >= hlim) begin
                    next_state = SDG_SPACE;
                    next_cnt   = 13'h0000;
                    next_age   = 13'h0000;
                end
            end
            SDG_SPACE: begin
                // Idle always adds one low cycle, so space ends one early to keep the top rate.
                if (cnt + 13'h0002 >= slim) begin
                    next_state = SDG_IDLE;
                end
            end
            default: next_state = SDG_IDLE;
        endcase
        if (next_state == SDG_HIGH && state != SDG_HIGH) begin
            next_pend = sum[`SDG_ACC_W];
            next_pos  = travel_sense_out ? position - 16'h0001 : position + 16'h0001;
        end
        next_step = (next_state == SDG_HIGH);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc              <= '0;
            pend             <= 1'b0;
            state            <= SDG_IDLE;
            cnt              <= 13'h0000;
            age              <= 13'h1FFF;
            motion_pulse_out <= 1'b0;
            travel_sense_out <= 1'b0;
            position         <= 16'h0000;
        end else begin
            acc              <= next_acc;
            pend             <= next_pend;
            state            <= next_state;
            cnt              <= next_cnt;
            age              <= next_age;
            motion_pulse_out <= next_step;
            travel_sense_out <= next_dir;
            position         <= next_pos;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sdg_cyc_t hi_cyc, dir_age, lo_cyc;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hi_cyc  <= 13'h0000;
            dir_age <= 13'h1FFF;
            lo_cyc  <= 13'h1FFF;
        end else begin
            hi_cyc  <= motion_pulse_out ? hi_cyc + 13'h0001 : 13'h0000;
            lo_cyc  <= motion_pulse_out ? 13'h0000 : (lo_cyc == 13'h1FFF) ? lo_cyc : lo_cyc + 13'h0001;
            dir_age <= (travel_sense_out != next_dir) ? 13'h0000 :
                       (dir_age == 13'h1FFF) ? dir_age : dir_age + 13'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_high_len;
        $fell(motion_pulse_out) |-> $past(hi_cyc) + 13'h0001 >= $past(hlim);
    endproperty
    a_high_len: assert property (p_high_len) else $error("step high too short");

    property p_dir_setup;
        $rose(motion_pulse_out) |-> $past(dir_age) >= $past(dlim) - 13'h0001;
    endproperty
    a_dir_setup: assert property (p_dir_setup) else $error("direction setup too short");

    property p_dir_hold;
        motion_pulse_out |=> $stable(travel_sense_out);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved at step");

    property p_pos_count;
        $rose(motion_pulse_out) |-> position == ($past(travel_sense_out) ?
            $past(position) - 16'h0001 : $past(position) + 16'h0001);
    endproperty
    a_pos_count: assert property (p_pos_count) else $error("position miscounted");

    property p_space;
        $rose(motion_pulse_out) |-> $past(lo_cyc) >= $past(slim) - 13'h0001;
    endproperty
    a_space: assert property (p_space) else $error("step space too short");
endmodule : sdg_chan

// ----------------------------------------
// Top with EPP link and dedicated I/O
// ----------------------------------------
module sdg_top (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic [7:0]           epp_data_in,
    output logic [7:0]                epp_data_out,
    output logic                      epp_data_oe,
    input  wire logic                 epp_write_n,
    input  wire logic                 epp_addr_strobe_n,
    input  wire logic                 epp_data_strobe_n,
    output logic                      epp_wait,
    output logic [`SDG_NCH-1:0]       motion_pulse_out,
    output logic [`SDG_NCH-1:0]       travel_sense_out,
    input  wire logic [`SDG_NIN-1:0]  dedicated_input,
    output logic [`SDG_NOUT-1:0]      dedicated_output,
    output logic                      led_out
);
    import sdg_pkg::*;
    logic       ds_q, as_q, busy, next_busy, ds_go, as_go;
    logic [7:0] addr, next_addr, rdat, next_rdat, fstage, next_fstage, ostage, next_ostage;
    logic [7:0] pos_hi [`SDG_NCH], next_pos_hi [`SDG_NCH];
    sdg_word_t  freq [`SDG_NCH], next_freq [`SDG_NCH], pos [`SDG_NCH];
    sdg_tick_t  slen, sspc, dtim, next_slen, next_sspc, next_dtim, wtk;
    logic [`SDG_NIN-1:0]  in_hold, next_in_hold;
    logic [`SDG_NOUT-1:0] next_out;
    logic                 commit;

    for (genvar c = 0; c < `SDG_NCH; c++) begin : g_ch
        sdg_chan u_chan (
            .sys_clk          (sys_clk),
            .resetn           (resetn),
            .freq             (freq[c]),
            .step_len         (slen),
            .step_space       (sspc),
            .dir_time         (dtim),
            .motion_pulse_out (motion_pulse_out[c]),
            .travel_sense_out (travel_sense_out[c]),
            .position         (pos[c])
        );
    end

    assign ds_go       = ds_q & ~epp_data_strobe_n;
    assign as_go       = as_q & ~epp_addr_strobe_n;
    assign epp_wait    = busy;
    assign epp_data_oe = ~(epp_data_strobe_n & epp_addr_strobe_n) & epp_write_n;
    assign epp_data_out = rdat;
    assign led_out     = motion_pulse_out[0] ^ travel_sense_out[0];
    // Writes beyond the longest time saturate rather than wrap.
    assign wtk = (epp_data_in > 8'(`SDG_TMAX_TICKS)) ? 5'(`SDG_TMAX_TICKS) : epp_data_in[4:0];

    always_comb begin
        next_busy    = (busy | ds_go | as_go) & ~(epp_data_strobe_n & epp_addr_strobe_n);
        next_addr    = addr;
        next_rdat    = rdat;
        next_fstage  = fstage;
        next_ostage  = ostage;
        next_pos_hi  = pos_hi;
        next_freq    = freq;
        next_slen    = slen;
        next_sspc    = sspc;
        next_dtim    = dtim;
        next_in_hold = in_hold;
        next_out     = dedicated_output;
        commit       = 1'b0;
        if (as_go && !epp_write_n) begin
            next_addr = epp_data_in;
        end else if (as_go) begin
            next_rdat = addr;
        end
        if (ds_go) begin
            next_addr = addr + 8'h01;
            if (!epp_write_n) begin
                if (addr < `SDG_A_SLEN && !addr[0]) begin
                    next_fstage = epp_data_in;
                end else if (addr < `SDG_A_SLEN) begin
                    next_freq[addr[2:1]] = {epp_data_in, fstage};
                end else begin
                    case (addr)
                        `SDG_A_SLEN:  next_slen = wtk;
                        `SDG_A_SSPC:  next_sspc = wtk;
                        `SDG_A_DTIM:  next_dtim = wtk;
                        `SDG_A_OUTLO: next_ostage = epp_data_in;
                        `SDG_A_OUTHI: begin
                            next_out = {epp_data_in[5:0], ostage};
                            commit   = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end else begin
                if (addr < `SDG_A_INLO && !addr[0]) begin
                    next_rdat = pos[addr[2:1]][7:0];
                    next_pos_hi[addr[2:1]] = pos[addr[2:1]][15:8];
                end else if (addr < `SDG_A_INLO) begin
                    next_rdat = pos_hi[addr[2:1]];
                end else if (addr == `SDG_A_INLO) begin
                    next_rdat    = dedicated_input[7:0];
                    next_in_hold = dedicated_input;
                end else if (addr == `SDG_A_INHI) begin
                    next_rdat = in_hold[15:8];
                end else begin
                    next_rdat = 8'h00;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ds_q             <= 1'b1;
            as_q             <= 1'b1;
            busy             <= 1'b0;
            addr             <= 8'h00;
            rdat             <= 8'h00;
            fstage           <= 8'h00;
            ostage           <= 8'h00;
            pos_hi           <= '{default: 8'h00};
            freq             <= '{default: `SDG_RST_FREQ};
            slen             <= `SDG_RST_TICKS;
            sspc             <= `SDG_RST_TICKS;
            dtim             <= `SDG_RST_TICKS;
            in_hold          <= 16'h0000;
            dedicated_output <= `SDG_RST_OUT;
        end else begin
            ds_q             <= epp_data_strobe_n;
            as_q             <= epp_addr_strobe_n;
            busy             <= next_busy;
            addr             <= next_addr;
            rdat             <= next_rdat;
            fstage           <= next_fstage;
            ostage           <= next_ostage;
            pos_hi           <= next_pos_hi;
            freq             <= next_freq;
            slen             <= next_slen;
            sspc             <= next_sspc;
            dtim             <= next_dtim;
            in_hold          <= next_in_hold;
            dedicated_output <= next_out;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_out_commit;
        $changed(dedicated_output) |-> $past(commit);
    endproperty
    a_out_commit: assert property (p_out_commit) else $error("outputs moved without commit");

    property p_in_hold;
        $changed(in_hold) |-> $past(ds_go && epp_write_n && addr == `SDG_A_INLO);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("inputs latched off cycle");

    property p_tmax;
        ds_go && !epp_write_n && addr == `SDG_A_SLEN && epp_data_in > 8'(`SDG_TMAX_TICKS) |=>
            slen == 5'(`SDG_TMAX_TICKS);
    endproperty
    a_tmax: assert property (p_tmax) else $error("timing above limit");

    property p_led;
        led_out == (motion_pulse_out[0] ^ travel_sense_out[0]);
    endproperty
    a_led: assert property (p_led) else $error("lamp mismatch");

    property p_wait;
        ds_go |=> epp_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait after data strobe");
endmodule : sdg_top

// file: rtl/sdg_cfg.svh
// What this block does
// - Four independent step channels, each able to step at up to 312.5 kHz.
// - Each channel drives a step clock output and a separate direction output.
// - Minimum step high length, step space and direction change time are enforced.
// - Timings are whole 1.6 us ticks, at most 49.6 us.
// - One direction time applies both before and after every direction change.
// - One shared set of timings governs all four channels.
// - Each channel's new step frequency takes effect on its own write.
// - All dedicated outputs change together at one update instant.
// - All dedicated inputs are snapshotted together into a holding register.
// - Each channel's feedback position is captured for readback on its own.
// - Fourteen dedicated outputs and sixteen dedicated inputs exist beside the channels.
// - All host traffic travels over an EPP parallel port link.
// - The lamp shows channel zero step XOR channel zero direction.
//
// Purpose: Constants of the step and direction generator.
// Assumes: System clock of 125 MHz.
// Notes:   Byte addresses are those of the EPP address cycle.
`ifndef SDG_CFG_SVH
`define SDG_CFG_SVH

`define SDG_NCH        4
`define SDG_NIN        16
`define SDG_NOUT       14
`define SDG_CLK_NS     8
`define SDG_TICK_NS    1600
`define SDG_TICK_CYC   ((`SDG_TICK_NS) / (`SDG_CLK_NS))
`define SDG_TMAX_NS    49600
`define SDG_TMAX_TICKS ((`SDG_TMAX_NS) / (`SDG_TICK_NS))
`define SDG_ACC_W      22
`define SDG_DIR_BIT    15
`define SDG_RST_TICKS  5'h01
`define SDG_RST_FREQ   16'h0000
`define SDG_RST_OUT    14'h0000

// Write map: frequency of channel c at 2c (low) and 2c+1 (high, applies).
`define SDG_A_FREQ0    8'h00
`define SDG_A_SLEN     8'h08
`define SDG_A_SSPC     8'h09
`define SDG_A_DTIM     8'h0A
`define SDG_A_OUTLO    8'h0B
`define SDG_A_OUTHI    8'h0C
// Read map: position of channel c at 2c (low, captures) and 2c+1 (high).
`define SDG_A_POS0     8'h00
`define SDG_A_INLO     8'h08
`define SDG_A_INHI     8'h09

`endif

// file: rtl/sdg_pkg.sv
// Purpose: Types of the step and direction generator.
// Assumes: Constants come from sdg_cfg.svh.
// Notes:   None.
package sdg_pkg;
    typedef enum logic [1:0] {
        SDG_IDLE  = 2'b00,
        SDG_SETUP = 2'b01,
        SDG_HIGH  = 2'b10,
        SDG_SPACE = 2'b11
    } sdg_st_e;
    typedef logic [4:0]  sdg_tick_t;
    typedef logic [12:0] sdg_cyc_t;
    typedef logic [15:0] sdg_word_t;
endpackage : sdg_pkg

// file: test/sdg_host_model.sv
// Purpose: Host side of the EPP link, driven through the xfer task.
// Assumes: The device raises wait within 50 cycles of a strobe.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
module sdg_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe,
    input  wire logic       epp_wait,
    output logic [7:0]      epp_data_in,
    output logic            epp_write_n,
    output logic            epp_addr_strobe_n,
    output logic            epp_data_strobe_n
);
    logic [7:0] host_d  = 8'h00;
    logic       host_oe = 1'b0;
    logic [7:0] last_d  = 8'h00;
    int         timeouts = 0;

    initial begin
        epp_write_n       = 1'b1;
        epp_addr_strobe_n = 1'b1;
        epp_data_strobe_n = 1'b1;
    end

    // Nobody holds the bus between transfers, so it must not keep a stale value.
    assign epp_data_in = dev_oe ? dev_data : (host_oe ? host_d : ~last_d);
    always @(posedge sys_clk) last_d <= epp_data_in;

    // ----------------------------------------
    // One strobe cycle
    // ----------------------------------------
    // Strobe is held for one more edge after wait is seen high, then released.
    task automatic xfer(input logic is_addr, input logic wr, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        #1;
        epp_write_n       = !wr;
        host_d            = d;
        host_oe           = wr;
        epp_addr_strobe_n = !is_addr;
        epp_data_strobe_n = is_addr;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (epp_wait !== 1'b1 && n < 50);
        if (epp_wait !== 1'b1) timeouts++;
        @(posedge sys_clk);
        #1;
        epp_addr_strobe_n = 1'b1;
        epp_data_strobe_n = 1'b1;
        host_oe           = 1'b0;
        epp_write_n       = 1'b1;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (epp_wait !== 1'b0 && n < 100);
        if (n >= 100) timeouts++;
    endtask : xfer
endmodule : sdg_host_model

// file: test/step_direction_generator_test.sv
// Purpose: Self-checking bench of the step and direction generator.
// Assumes: Host model drives the EPP link; inputs change 1 ns after the edge.
// Notes:   Waveform widths are measured on every channel all the time.
`timescale 1ns/1ps
`include "sdg_cfg.svh"
module step_direction_generator_test;
    import sdg_pkg::*;
    localparam int TICK = `SDG_TICK_CYC;
    logic                 sys_clk = 1'b0;
    logic                 resetn  = 1'b0;
    logic [7:0]           epp_data_in, epp_data_out;
    logic                 epp_data_oe, epp_write_n, epp_addr_strobe_n, epp_data_strobe_n, epp_wait, led_out;
    logic [`SDG_NCH-1:0]  motion_pulse_out, travel_sense_out, mp_d = '0, ts_d = '0;
    logic [`SDG_NIN-1:0]  dedicated_input = '0, a;
    logic [`SDG_NOUT-1:0] dedicated_output, do_d = '0, o;
    logic                 w_d = 1'b0;
    logic [7:0]           rd_q[$];
    logic [`SDG_NOUT-1:0] out_q[$];
    logic [15:0]          p;
    int failures = 0, n_checks = 0, len_c = 1, spc_c = 1, dt_c = 1, k;
    int hi_n[4], lo_n[4], fwd[4], rev[4], dsince[4];
    int lens[3] = '{0, 3, 40};

    always #4 sys_clk = ~sys_clk;

    sdg_top DUT (.sys_clk(sys_clk), .resetn(resetn), .epp_data_in(epp_data_in), .epp_data_out(epp_data_out),
        .epp_data_oe(epp_data_oe), .epp_write_n(epp_write_n), .epp_addr_strobe_n(epp_addr_strobe_n),
        .epp_data_strobe_n(epp_data_strobe_n), .epp_wait(epp_wait), .motion_pulse_out(motion_pulse_out),
        .travel_sense_out(travel_sense_out), .dedicated_input(dedicated_input),
        .dedicated_output(dedicated_output), .led_out(led_out));
    sdg_host_model host (.sys_clk(sys_clk), .dev_data(epp_data_out), .dev_oe(epp_data_oe), .epp_wait(epp_wait),
        .epp_data_in(epp_data_in), .epp_write_n(epp_write_n), .epp_addr_strobe_n(epp_addr_strobe_n),
        .epp_data_strobe_n(epp_data_strobe_n));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic results;
        failures += host.timeouts;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] adr, input logic [7:0] d[$]);
        host.xfer(1'b1, 1'b1, adr);
        foreach (d[i]) host.xfer(1'b0, 1'b1, d[i]);
    endtask : wr

    // Expected bytes are noted before the strobe; the monitor compares them.
    task automatic rd(input logic [7:0] adr, input logic [7:0] e[$]);
        host.xfer(1'b1, 1'b1, adr);
        foreach (e[i]) begin
            rd_q.push_back(e[i]);
            host.xfer(1'b0, 1'b0, 8'h00);
        end
    endtask : rd

    function automatic int eff(input int v);
        return (v == 0) ? 1 : ((v > 31) ? 31 : v);
    endfunction : eff

    task automatic tim(input int l, input int s, input int d);
        wr(`SDG_A_SLEN, '{8'(l), 8'(s), 8'(d)});
        len_c = eff(l);
        spc_c = eff(s);
        dt_c  = eff(d);
    endtask : tim

    task automatic freq(input int c, input logic [15:0] w);
        wr(8'(2 * c), '{w[7:0], w[15:8]});
    endtask : freq

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge sys_clk) begin
        #2;
        if (resetn) begin
            check(led_out, motion_pulse_out[0] ^ travel_sense_out[0], "lamp");
            if (!epp_write_n) check(epp_data_oe, 1'b0, "bus clash");
            if (epp_wait && !w_d && epp_data_oe) check(epp_data_out, rd_q.pop_front(), "read data");
            if (dedicated_output !== do_d) check(dedicated_output, (out_q.size() > 0) ? out_q.pop_front() : do_d,
                "outputs");
            for (int c = 0; c < 4; c++) begin
                if (mp_d[c] && !motion_pulse_out[c]) begin
                    check(hi_n[c], len_c * TICK, "step high");
                    lo_n[c] = 0;
                end
                if (!mp_d[c] && motion_pulse_out[c]) begin
                    check(lo_n[c] >= spc_c * TICK, 1, "step space");
                    check(dsince[c] >= dt_c * TICK, 1, "dir setup");
                    if (travel_sense_out[c]) rev[c]++;
                    else fwd[c]++;
                    hi_n[c] = 0;
                end
                if (ts_d[c] !== travel_sense_out[c]) begin
                    check(lo_n[c] >= dt_c * TICK && !motion_pulse_out[c], 1, "dir hold");
                    dsince[c] = 0;
                end
                if (motion_pulse_out[c]) hi_n[c]++;
                else lo_n[c]++;
                dsince[c]++;
            end
            mp_d = motion_pulse_out;
            ts_d = travel_sense_out;
            do_d = dedicated_output;
            w_d  = epp_wait;
        end
    end

    initial begin
        #640000;
        failures++;
        results();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h855092de));
        idle(3);
        resetn = 1'b1;
        idle(2);
        check({dedicated_output, motion_pulse_out, travel_sense_out, led_out}, 0, "reset");
        tim(1, 1, 2);
        o = 14'($urandom) | 14'h2001;
        out_q.push_back(o);
        wr(`SDG_A_OUTLO, '{o[7:0], {2'b00, o[13:8]}});
        wr(8'h30, '{8'hFF});
        a = 16'($urandom);
        dedicated_input = a;
        idle(2);
        rd(`SDG_A_INLO, '{a[7:0]});
        rd_q.push_back(8'h09);
        host.xfer(1'b1, 1'b0, 8'h00);
        dedicated_input = ~a;
        rd(`SDG_A_INHI, '{a[15:8]});
        rd(8'h20, '{8'h00});
        freq(0, 16'h28F6);
        freq(2, 16'h0800);
        idle(4000);
        check(fwd[0] >= 8, 1, "max rate");
        freq(0, 16'hA8F6);
        idle(4000);
        freq(0, 16'h0000);
        freq(2, 16'h0000);
        idle(8000);
        for (int c = 0; c < 4; c += 2) begin
            p = 16'(fwd[c] - rev[c]);
            rd(8'(2 * c), '{p[7:0], p[15:8]});
        end
        check(fwd[1] + rev[1] + fwd[3] + rev[3], 0, "idle channels");
        check(rev[0] > 0 && fwd[2] > 0, 1, "both senses");
        foreach (lens[i]) begin
            tim(lens[i], i + 1, 1);
            freq(2, 16'h28F6);
            k = fwd[2];
            for (int n = 0; n < 20000 && fwd[2] < k + 2; n++) idle(1);
            check(fwd[2] >= k + 2, 1, "steps run");
            freq(2, 16'h0000);
            idle(7000);
        end
        check(out_q.size() + rd_q.size(), 0, "notes left");
        results();
    end
endmodule : step_direction_generator_test
